//--- fieldbus_temp_pkg.sv
/*
  Shared types and constants of the field-bus temperature node protocol logic.
  Assumes a line framer outside that delivers checked telegrams and sends replies.
*/
`default_nettype none
package fieldbus_temp_pkg;

  // Register numbers
  localparam logic [7:0] REG_TEMP_FIRST = 8'h01;
  localparam logic [7:0] REG_TEMP_LAST  = 8'h04;
  localparam logic [7:0] REG_BAUD       = 8'h05;
  localparam logic [7:0] REG_ADDR       = 8'h06;
  localparam logic [7:0] REG_STATUS     = 8'h0A;

  localparam logic [7:0] BROADCAST_ADDR = 8'hFF;
  localparam logic [3:0] CRC_ERR_LIMIT  = 4'hB;
  localparam logic [7:0] ADDR_DECADE    = 8'h0A;

  // Baud codes
  localparam logic [3:0] BAUD_CODE_MIN     = 4'h4;
  localparam logic [3:0] BAUD_CODE_MAX     = 4'h9;
  localparam logic [3:0] BAUD_CODE_DEFAULT = 4'h7;
  localparam logic [3:0] BAUD_CODE_FAST    = 4'h8;
  localparam logic [3:0] BAUD_CODE_4800    = 4'h6;
  localparam logic [31:0] BAUD_1200  = 32'h0000_04B0;
  localparam logic [31:0] BAUD_2400  = 32'h0000_0960;
  localparam logic [31:0] BAUD_4800  = 32'h0000_12C0;
  localparam logic [31:0] BAUD_9600  = 32'h0000_2580;
  localparam logic [31:0] BAUD_19200 = 32'h0000_4B00;
  localparam logic [31:0] BAUD_38400 = 32'h0000_9600;

  // Status word bit positions
  localparam int ST_RECOGNISED = 0;
  localparam int ST_BROADCAST  = 1;
  localparam int ST_MASTER     = 2;
  localparam int ST_CRC_OK     = 3;
  localparam int ST_RUNNING    = 5;
  localparam int ST_EE_BUS_OK  = 8;
  localparam int ST_EE_DATA_OK = 9;
  localparam int ST_BAUD_EE    = 10;

  // Temperature conversion: tenths = raw * 750 / 255 - 350
  localparam logic [17:0] TEMP_SCALE  = 18'h2F0EE;
  localparam logic [25:0] TEMP_ROUND  = 26'h0008000;
  localparam int          TEMP_SHIFT  = 16;
  localparam logic [15:0] TEMP_OFFSET = 16'h015E;
  localparam logic [15:0] TEMP_OPEN   = 16'h019A;

  typedef enum logic [1:0] {
    CMD_READ_REG  = 2'h0,
    CMD_WRITE_REG = 2'h1,
    CMD_WRITE_OUT = 2'h2,
    CMD_OTHER     = 2'h3
  } cmd_t;

  typedef enum logic [1:0] {
    RSP_ACK  = 2'h0,
    RSP_NAK  = 2'h1,
    RSP_DATA = 2'h2
  } rsp_kind_t;

  typedef struct packed {
    cmd_t        cmd;
    logic [7:0]  station;
    logic [7:0]  reg_num;
    logic [31:0] wdata;
    logic        crc_ok;
    logic        from_master;
  } telegram_t;

  typedef struct packed {
    rsp_kind_t   kind;
    logic [31:0] data;
  } reply_t;

endpackage
`default_nettype wire

//--- fieldbus_temp_node.sv
/*
  Protocol logic of a four-input temperature field-bus node: telegram decode,
  register reads, baud setting, broadcast, CRC error counting and status word.
  Assumes an external framer/UART, A/D converter and EEPROM controller.
*/
`timescale 1ns/1ps
`default_nettype none
module fieldbus_temp_node
  import fieldbus_temp_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // Telegrams from the framer
  input  wire fieldbus_temp_pkg::telegram_t tlg,
  input  wire logic                         tlg_valid,
  output logic                              tlg_ready,
  // Replies to the framer
  output fieldbus_temp_pkg::reply_t         rsp,
  output logic                              rsp_valid,
  input  wire logic                         rsp_ready,
  // A/D samples and sensor presence
  input  wire logic [31:0]                  adc_raw,
  input  wire logic [3:0]                   sensor_present,
  // Address switches, BCD
  input  wire logic [3:0]                   addr_units,
  input  wire logic [3:0]                   addr_tens,
  // EEPROM controller
  input  wire logic                         ee_ready,
  input  wire logic                         ee_bus_ok,
  input  wire logic                         ee_data_ok,
  input  wire logic [3:0]                   ee_baud_code,
  output logic                              ee_write,
  output logic [3:0]                        ee_write_code,
  // Line control
  output logic [3:0]                        baud_code,
  output logic                              autobaud_en,
  output logic [3:0]                        autobaud_min_code
);
  import fieldbus_temp_pkg::*;

  typedef enum logic [2:0] {
    S_LOAD  = 3'h1,
    S_IDLE  = 3'h2,
    S_REPLY = 3'h4
  } state_t;

  state_t      state_r;
  state_t      state_nxt;
  reply_t      rsp_r;
  logic [3:0]  baud_r;
  logic        baud_ee_r;
  logic [3:0]  crc_err_r;
  logic [3:0]  st_flags_r;
  logic        running_r;
  logic        ee_write_r;
  logic [3:0]  ee_code_r;

  // Per-input conversion
  logic [15:0] temp_val [4];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_conv
      wire logic [7:0]  raw    = adc_raw[gi*8 +: 8];
      wire logic [25:0] prod   = (26'(raw) * 26'(TEMP_SCALE)) + TEMP_ROUND;
      wire logic [15:0] tenths = 16'(prod >> TEMP_SHIFT);
      assign temp_val[gi] = sensor_present[gi] ? (tenths - TEMP_OFFSET) : TEMP_OPEN;
    end
  endgenerate

  // Station address from switches
  wire logic [7:0] own_addr = 8'(addr_tens * ADDR_DECADE) + {4'h0, addr_units};

  // Telegram decode
  wire logic take       = (state_r == S_IDLE) && tlg_valid;
  wire logic is_bcast   = (tlg.station == BROADCAST_ADDR)
                       && (tlg.cmd == CMD_WRITE_REG || tlg.cmd == CMD_WRITE_OUT);
  wire logic is_own     = (tlg.station == own_addr);
  wire logic recognised = tlg.crc_ok && (is_own || is_bcast);
  wire logic do_reply   = recognised && !is_bcast;
  wire logic reg_is_temp = (tlg.reg_num >= REG_TEMP_FIRST) && (tlg.reg_num <= REG_TEMP_LAST);
  wire logic [1:0] temp_idx = 2'(tlg.reg_num - REG_TEMP_FIRST);
  wire logic [3:0] wcode    = tlg.wdata[3:0];
  wire logic code_ok = (tlg.wdata[31:4] == 28'h0) && (wcode >= BAUD_CODE_MIN) && (wcode <= BAUD_CODE_MAX);
  wire logic baud_wr = take && recognised && tlg.cmd == CMD_WRITE_REG
                    && tlg.reg_num == REG_BAUD && code_ok;

  // Baud code to plain rate
  logic [31:0] baud_plain;
  always_comb begin
    case (baud_r)
      4'h4:    baud_plain = BAUD_1200;
      4'h5:    baud_plain = BAUD_2400;
      4'h6:    baud_plain = BAUD_4800;
      4'h8:    baud_plain = BAUD_19200;
      4'h9:    baud_plain = BAUD_38400;
      default: baud_plain = BAUD_9600;
    endcase
  end

  // Status word
  logic [31:0] status_word;
  always_comb begin
    status_word                = 32'h0;
    status_word[ST_RECOGNISED] = st_flags_r[0];
    status_word[ST_BROADCAST]  = st_flags_r[1];
    status_word[ST_MASTER]     = st_flags_r[2];
    status_word[ST_CRC_OK]     = st_flags_r[3];
    status_word[ST_RUNNING]    = running_r;
    status_word[ST_EE_BUS_OK]  = ee_bus_ok;
    status_word[ST_EE_DATA_OK] = ee_data_ok;
    status_word[ST_BAUD_EE]    = baud_ee_r;
  end

  // Reply selection
  reply_t rsp_nxt;
  always_comb begin
    rsp_nxt = '{kind: RSP_NAK, data: 32'h0};
    case (tlg.cmd)
      CMD_READ_REG: begin
        if (reg_is_temp) begin
          rsp_nxt = '{kind: RSP_DATA, data: {{16{temp_val[temp_idx][15]}}, temp_val[temp_idx]}};
        end else if (tlg.reg_num == REG_BAUD) begin
          rsp_nxt = '{kind: RSP_DATA, data: baud_plain};
        end else if (tlg.reg_num == REG_ADDR) begin
          rsp_nxt = '{kind: RSP_DATA, data: {24'h0, own_addr}};
        end else if (tlg.reg_num == REG_STATUS) begin
          rsp_nxt = '{kind: RSP_DATA, data: status_word};
        end
      end
      CMD_WRITE_REG: begin
        if (tlg.reg_num == REG_BAUD && code_ok) begin
          rsp_nxt = '{kind: RSP_ACK, data: 32'h0};
        end
      end
      default: rsp_nxt = '{kind: RSP_NAK, data: 32'h0};
    endcase
  end

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_LOAD: begin
        if (ee_ready) begin
          state_nxt = S_IDLE;
        end
      end
      S_IDLE: begin
        if (take && do_reply) begin
          state_nxt = S_REPLY;
        end
      end
      S_REPLY: begin
        if (rsp_ready) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_LOAD;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= S_LOAD;
      rsp_r   <= '{kind: RSP_NAK, data: 32'h0};
    end else begin
      state_r <= state_nxt;
      if (take && do_reply) begin
        rsp_r <= rsp_nxt;
      end
    end
  end

  // Baud rate, restored once from EEPROM
  wire logic ee_code_ok = ee_data_ok && (ee_baud_code >= BAUD_CODE_MIN) && (ee_baud_code <= BAUD_CODE_MAX);
  wire logic ee_load    = (state_r == S_LOAD) && ee_ready && ee_code_ok;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      baud_r    <= BAUD_CODE_DEFAULT;
      baud_ee_r <= 1'b0;
    end else if (ee_load) begin
      baud_r    <= ee_baud_code;
      baud_ee_r <= 1'b1;
    end else if (baud_wr) begin
      baud_r    <= wcode;
      baud_ee_r <= 1'b0;
    end
  end

  // Persist new baud code
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ee_write_r <= 1'b0;
      ee_code_r  <= BAUD_CODE_DEFAULT;
    end else begin
      ee_write_r <= baud_wr;
      if (baud_wr) begin
        ee_code_r <= wcode;
      end
    end
  end

  // Consecutive master CRC errors
  wire logic crc_bad_m = take && tlg.from_master && !tlg.crc_ok;
  wire logic crc_good  = take && tlg.crc_ok;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      crc_err_r <= 4'h0;
    end else if (crc_good) begin
      crc_err_r <= 4'h0;
    end else if (crc_bad_m && crc_err_r != CRC_ERR_LIMIT) begin
      crc_err_r <= crc_err_r + 4'h1;
    end
  end

  // Last-transmission flags and running bit
  wire logic status_read = take && do_reply && tlg.cmd == CMD_READ_REG && tlg.reg_num == REG_STATUS;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_flags_r <= 4'h0;
      running_r  <= 1'b0;
    end else begin
      if (take) begin
        st_flags_r <= {tlg.crc_ok, tlg.from_master, tlg.station == BROADCAST_ADDR, recognised};
      end
      if (status_read) begin
        running_r <= 1'b1;
      end
    end
  end

  // Outputs
  assign tlg_ready         = (state_r == S_IDLE);
  assign rsp_valid         = (state_r == S_REPLY);
  assign rsp               = rsp_r;
  assign ee_write          = ee_write_r;
  assign ee_write_code     = ee_code_r;
  assign baud_code         = baud_r;
  assign autobaud_en       = (crc_err_r == CRC_ERR_LIMIT);
  assign autobaud_min_code = (baud_r >= BAUD_CODE_FAST) ? BAUD_CODE_4800 : BAUD_CODE_MIN;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_bcast_no_reply: assert property (take && is_bcast |=> !rsp_valid)
    else $error("reply after broadcast");
  a_nak_unknown: assert property (take && do_reply && tlg.cmd == CMD_OTHER |=> rsp_valid && rsp.kind == RSP_NAK)
    else $error("unsupported telegram not NAKed");
  a_autobaud_count: assert property (autobaud_en |-> crc_err_r == CRC_ERR_LIMIT && $past(crc_bad_m) || $past(autobaud_en))
    else $error("autobaud enabled without error run");
  a_autobaud_clear: assert property (crc_good |=> !autobaud_en)
    else $error("autobaud stays after good CRC");
  a_temp_read: assert property (take && do_reply && tlg.cmd == CMD_READ_REG && reg_is_temp
      |=> rsp.data[15:0] == $past(temp_val[temp_idx]))
    else $error("wrong temperature returned");
  a_open_input: assert property (!sensor_present[0] |-> temp_val[0] == TEMP_OPEN)
    else $error("open input not at 41 degrees");
  a_baud_write: assert property (baud_wr && !ee_load |=> baud_r == $past(wcode) ##1 ee_write == 1'b0)
    else $error("baud write not applied");
  a_bad_code: assert property (take && tlg.cmd == CMD_WRITE_REG && !code_ok && state_r != S_LOAD |=> $stable(baud_r))
    else $error("invalid baud code changed rate");
  a_status_flags: assert property (take |=> st_flags_r[3] == $past(tlg.crc_ok) && st_flags_r[2] == $past(tlg.from_master))
    else $error("status flags not updated");
  a_reply_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("reply dropped before taken");

  // Last-transmission flags, status reply and running bit
  a_status_recog: assert property (take |=> st_flags_r[0] == $past(recognised))
    else $error("recognised flag not updated");
  a_status_bcast: assert property (take |=> st_flags_r[1] == $past(tlg.station == BROADCAST_ADDR))
    else $error("broadcast flag not updated");
  a_status_kind: assert property (status_read |=> rsp.kind == RSP_DATA)
    else $error("status read not answered with data");
  a_running_bit: assert property (status_read |=> running_r)
    else $error("running bit not set");

  // Register reads
  a_addr_read: assert property (take && do_reply && tlg.cmd == CMD_READ_REG && tlg.reg_num == REG_ADDR
      |=> rsp.data == {24'h0, $past(own_addr)})
    else $error("wrong station address returned");
  a_baud_plain: assert property (baud_r == BAUD_CODE_DEFAULT |-> baud_plain == BAUD_9600)
    else $error("default rate not shown as 9600");

  // Baud rate and its storage
  a_ee_restore: assert property (ee_load |=> baud_ee_r && baud_r == $past(ee_baud_code))
    else $error("stored baud code not restored");
  a_ee_write_code: assert property (ee_write |-> ee_write_code == baud_code)
    else $error("stored code differs from active code");
  a_baud_legal: assert property (baud_code >= BAUD_CODE_MIN && baud_code <= BAUD_CODE_MAX)
    else $error("active baud code out of range");
  a_min_code_fast: assert property (baud_code >= BAUD_CODE_FAST |-> autobaud_min_code == BAUD_CODE_4800)
    else $error("slow rates still required at fast setting");
  a_bcast_baud: assert property (take && is_bcast && tlg.cmd == CMD_WRITE_REG && tlg.reg_num == REG_BAUD
      && code_ok |=> baud_code == $past(wcode))
    else $error("broadcast baud write not applied");

  // Reply gating and error counter
  a_no_reply_other: assert property (take && !is_own && !is_bcast |=> !rsp_valid)
    else $error("reply to another station");
  a_bad_crc_silent: assert property (take && !tlg.crc_ok |=> !rsp_valid)
    else $error("reply to telegram with bad CRC");
  a_busy_refuse: assert property (rsp_valid |-> !tlg_ready)
    else $error("telegram accepted while reply pending");
  a_counter_sat: assert property (crc_err_r <= CRC_ERR_LIMIT)
    else $error("error counter beyond limit");

  c_temp_read: cover property (take && do_reply && reg_is_temp ##1 rsp_valid);
  c_bcast_write: cover property (baud_wr && is_bcast);
  c_autobaud: cover property ($rose(autobaud_en));
  c_ee_restore: cover property (ee_load);
  c_nak_reply: cover property (rsp_valid && rsp.kind == RSP_NAK);

endmodule
`default_nettype wire

//--- fieldbus_master_model.sv
/*
  Field-bus master model: offers telegrams to the node and takes its replies.
  Assumes the bench calls xfer and ends the run when hang rises.
*/
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model (
  // Clock
  input  wire logic                          clk,
  // Telegrams out
  output var fieldbus_temp_pkg::telegram_t   tlg,
  output var logic                           tlg_valid,
  input  wire logic                          tlg_ready,
  // Replies in
  input  wire fieldbus_temp_pkg::reply_t     rsp,
  input  wire logic                          rsp_valid,
  output var logic                           rsp_ready,
  // Wait bound used up
  output var logic                           hang
);
  import fieldbus_temp_pkg::*;

  initial begin
    tlg = '0;
    tlg_valid = 1'b0;
    rsp_ready = 1'b0;
    hang = 1'b0;
  end

  // One telegram, then up to stall+6 cycles for its reply
  task automatic xfer(input telegram_t t, input int stall, output logic got, output reply_t r);
    int n;
    got = 1'b0;
    r = '0;
    @(posedge clk);
    #1;
    tlg = t;
    tlg_valid = 1'b1;
    for (n = 0; n < 50 && !tlg_ready; n++) begin
      @(posedge clk);
      #1;
    end
    if (!tlg_ready) hang = 1'b1;
    @(posedge clk);
    #1;
    tlg_valid = 1'b0;
    // Released lines must not keep the old value
    tlg = telegram_t'(~t);
    for (n = 0; n < stall + 6 && !got; n++) begin
      rsp_ready = (n >= stall);
      if (rsp_valid && rsp_ready) begin
        r = rsp;
        got = 1'b1;
      end
      @(posedge clk);
      #1;
    end
    rsp_ready = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- fieldbus_temp_node_tb_top.sv
/*
  Bench of the field-bus temperature node: telegrams through the master model,
  replies and line outputs compared with expected values.
  Assumes the node package and the master model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module fieldbus_temp_node_tb_top;
  import fieldbus_temp_pkg::*;
  localparam logic [7:0] ME   = 8'h25;
  localparam logic [1:0] NONE = 2'h3;
  logic        clk, nrst, tlg_valid, tlg_ready, rsp_valid, rsp_ready, hang;
  telegram_t   tlg;
  reply_t      rsp;
  logic [31:0] adc_raw;
  logic [3:0]  sensor_present, addr_units, addr_tens, ee_baud_code, ee_write_code, baud_code, autobaud_min_code;
  logic        ee_ready, ee_bus_ok, ee_data_ok, ee_write, autobaud_en, mst;
  int          error_cnt, comparisons, ee_cnt, stall;
  logic [31:0] bauds [6];

  fieldbus_temp_node dut_u (.clk, .nrst, .tlg, .tlg_valid, .tlg_ready, .rsp, .rsp_valid, .rsp_ready,
    .adc_raw, .sensor_present, .addr_units, .addr_tens, .ee_ready, .ee_bus_ok, .ee_data_ok,
    .ee_baud_code, .ee_write, .ee_write_code, .baud_code, .autobaud_en, .autobaud_min_code);
  fieldbus_master_model m_u (.clk, .tlg, .tlg_valid, .tlg_ready, .rsp, .rsp_valid, .rsp_ready, .hang);

  always #10 clk = ~clk;
  always @(posedge clk) if (ee_write === 1'b1) ee_cnt++;
  always @(posedge hang) begin
    error_cnt++;
    tally_and_finish;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Expected kind NONE means no reply may come
  task automatic tx(input cmd_t c, input logic [7:0] st, rg, input logic [31:0] wd, input logic crc,
                    input logic [1:0] k, input logic [31:0] d);
    logic   got;
    reply_t r;
    m_u.xfer('{c, st, rg, wd, crc, mst}, stall, got, r);
    chk({31'h0, got}, {31'h0, k != NONE});
    if (got && k != NONE) chk({30'h0, r.kind}, {30'h0, k});
    if (got && k == RSP_DATA) chk(r.data, d);
  endtask

  task automatic rd(input logic [7:0] rg, input logic [31:0] d);
    tx(CMD_READ_REG, ME, rg, 32'h0, 1'b1, RSP_DATA, d);
  endtask

  // Low nibble is {crc, master, broadcast, recognised}
  task automatic st_rd(input logic [3:0] low, input logic run, b10);
    rd(REG_STATUS, {21'h0, b10, ee_data_ok, ee_bus_ok, 2'h0, run, 1'b0, low});
  endtask

  task automatic wb(input logic [7:0] st, input logic [31:0] code, input logic [1:0] k);
    tx(CMD_WRITE_REG, st, REG_BAUD, code, 1'b1, k, 32'h0);
  endtask

  function automatic logic [31:0] tmp(input int raw);
    return (raw * 1500 + 255) / 510 - 350;
  endfunction

  task automatic do_reset(input logic [3:0] code);
    nrst = 1'b0;
    ee_ready = 1'b0;
    ee_baud_code = code;
    repeat (16) @(posedge clk);
    #1;
    chk({28'h0, baud_code}, 32'h7);
    chk({28'h0, autobaud_min_code}, 32'h4);
    nrst = 1'b1;
    @(posedge clk);
    #1;
    ee_ready = 1'b1;
  endtask

  initial begin
    clk = 1'b0;
    adc_raw = 32'hFF64_0080;
    sensor_present = 4'h7;
    addr_units = 4'h7;
    addr_tens = 4'h3;
    ee_bus_ok = 1'b1;
    ee_data_ok = 1'b1;
    mst = 1'b1;
    stall = 0;
    error_cnt = 0;
    comparisons = 0;
    ee_cnt = 0;
    bauds = '{BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600, BAUD_19200, BAUD_38400};
    do_reset(4'hF);
    rd(REG_ADDR, 32'h25);
    st_rd(4'hD, 1'b0, 1'b0);
    st_rd(4'hD, 1'b1, 1'b0);
    for (int i = 1; i <= 4; i++) begin
      stall = i;
      rd(8'(i), sensor_present[i-1] ? tmp(adc_raw[8*i-8 +: 8]) : 32'h19A);
    end
    stall = 0;
    for (int i = 4; i <= 9; i++) begin
      wb(ME, i, RSP_ACK);
      chk({28'h0, baud_code}, i);
      chk({28'h0, ee_write_code}, i);
      chk({28'h0, autobaud_min_code}, i >= 8 ? 32'h6 : 32'h4);
      rd(REG_BAUD, bauds[i-4]);
    end
    chk(ee_cnt, 32'h6);
    wb(ME, 32'h3, RSP_NAK);
    wb(ME, 32'hA, RSP_NAK);
    wb(ME, 32'h109, RSP_NAK);
    chk({28'h0, baud_code}, 32'h9);
    chk(ee_cnt, 32'h6);
    tx(CMD_READ_REG, ME, 8'h07, 32'h0, 1'b1, RSP_NAK, 32'h0);
    tx(CMD_READ_REG, ME, 8'h00, 32'h0, 1'b1, RSP_NAK, 32'h0);
    tx(CMD_WRITE_REG, ME, REG_ADDR, 32'h5, 1'b1, RSP_NAK, 32'h0);
    tx(CMD_WRITE_OUT, ME, 8'h01, 32'h1, 1'b1, RSP_NAK, 32'h0);
    tx(CMD_OTHER, ME, 8'h01, 32'h0, 1'b1, RSP_NAK, 32'h0);
    rd(REG_ADDR, 32'h25);
    wb(BROADCAST_ADDR, 32'h5, NONE);
    chk({28'h0, baud_code}, 32'h5);
    st_rd(4'hF, 1'b1, 1'b0);
    tx(CMD_WRITE_OUT, BROADCAST_ADDR, 8'h01, 32'h1, 1'b1, NONE, 32'h0);
    mst = 1'b0;
    tx(CMD_READ_REG, 8'h24, 8'h01, 32'h0, 1'b1, NONE, 32'h0);
    mst = 1'b1;
    ee_bus_ok = 1'b0;
    ee_data_ok = 1'b0;
    st_rd(4'h8, 1'b1, 1'b0);
    ee_bus_ok = 1'b1;
    ee_data_ok = 1'b1;
    repeat (10) tx(CMD_READ_REG, ME, 8'h01, 32'h0, 1'b0, NONE, 32'h0);
    chk({31'h0, autobaud_en}, 32'h0);
    tx(CMD_READ_REG, ME, 8'h01, 32'h0, 1'b0, NONE, 32'h0);
    chk({31'h0, autobaud_en}, 32'h1);
    st_rd(4'h4, 1'b1, 1'b0);
    chk({31'h0, autobaud_en}, 32'h0);
    do_reset(4'h8);
    rd(REG_BAUD, BAUD_19200);
    chk({28'h0, autobaud_min_code}, 32'h6);
    st_rd(4'hD, 1'b0, 1'b1);
    wb(ME, 32'h7, RSP_ACK);
    st_rd(4'hD, 1'b1, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
